// >>> design/hrpc_seq.sv
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "hrpc_regs.svh"
module hrpc_seq (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             halted,
  output logic             busy,
  output logic             tgt_req,
  output logic             tgt_we,
  output logic [15:0]      tgt_addr,
  output logic [15:0]      tgt_wdata,
  input  wire logic [15:0] tgt_rdata,
  input  wire logic        tgt_rdy
);
  import hrpc_pkg::*;

  // ****************************************************************
  // control state
  // ****************************************************************
  hrpc_state_t  state;
  hrpc_state_t  next_state;
  logic [4:0]   idx;
  logic [4:0]   next_idx;
  logic [4:0]   ctrl;
  logic [15:0]  tab [0:19];
  logic [19:0]  modified;
  logic         port_start;
  logic         port_we;
  logic [15:0]  port_addr;
  logic [15:0]  port_wdata;
  logic         port_done;
  logic [15:0]  port_rdata;

  hrpc_family_t family;
  assign family = hrpc_family_t'(ctrl[`HRPC_CTRL_FAM_HI:`HRPC_CTRL_FAM_LO]);
  wire newest   = (family == HRPC_FAM_NEWEST);
  wire oldest   = (family == HRPC_FAM_OLDEST);
  wire irq_during_halt_switch      = ctrl[`HRPC_CTRL_IDP];
  wire read_serial_status_switch      = ctrl[`HRPC_CTRL_RSS];
  wire chip_select_readback_switch      = ctrl[`HRPC_CTRL_RCS];

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire acc       = psel & penable;
  wire hit_ctrl  = (paddr == `HRPC_OFS_CTRL);
  wire hit_cmd   = (paddr == `HRPC_OFS_CMD);
  wire hit_stat  = (paddr == `HRPC_OFS_STATUS);
  wire hit_tab   = (paddr >= `HRPC_OFS_TABLE) &&
                   (paddr < `HRPC_OFS_TBL_END) && (paddr[1:0] == 2'h0);
  wire [4:0] tix = 5'(paddr[11:2] - 10'(`HRPC_OFS_TABLE >> 2));
  wire tab_err   = hit_tab & busy & pwrite;
  wire bad_addr  = !(hit_ctrl | hit_cmd | hit_stat | hit_tab);
  wire host_wr   = acc & pwrite & hit_tab & !busy;
  wire halt_req  = acc & pwrite & hit_cmd & pwdata[`HRPC_CMD_HALT];
  wire res_req   = acc & pwrite & hit_cmd & pwdata[`HRPC_CMD_RESUME];

  assign pready  = 1'b1;
  assign pslverr = acc & (bad_addr | tab_err);
  assign busy    = (state != ST_IDLE);

  // fixed read-only ones of the older chip selects
  function automatic logic [15:0] ones_of(input logic [4:0] i,
                                          input logic nw);
    logic [15:0] v;
    v = 16'h0000;
    if (!nw) begin
      unique case (i)
        `HRPC_E_LOWER_MEMORY_SELECT_CTRL:  v = `HRPC_ONES_LOWER_MEMORY_SELECT_CTRL;
        `HRPC_E_MBASE: v = `HRPC_ONES_MBASE;
        `HRPC_E_PCS:   v = `HRPC_ONES_PCS;
        `HRPC_E_UPPER_MEMORY_SELECT_CTRL:  v = `HRPC_ONES_UPPER_MEMORY_SELECT_CTRL;
        default:       v = 16'h0000;
      endcase
    end
    return v;
  endfunction

  // read view of the snapshot table
  wire [15:0] tab_view = tab[tix] | ones_of(tix, newest);
  assign prdata =
    !(psel && !pwrite) ? 32'h0000_0000 :
    hit_ctrl ? {27'h0, ctrl} :
    hit_stat ? {24'h0, 3'(state), 3'h0, busy, halted} :
    hit_tab  ? {16'h0, tab_view} : 32'h0000_0000;

  // control register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ctrl <= `HRPC_CTRL_RESET;
    else if (acc && pwrite && hit_ctrl) ctrl <= pwdata[4:0];
  end

  // ****************************************************************
  // entry classes
  // ****************************************************************
  wire is_cs4    = (idx <= `HRPC_E_PCS);
  wire is_cs     = (idx <= `HRPC_E_UPPER_MEMORY_SELECT_CTRL);
  wire is_poll   = (idx == `HRPC_E_POLLST) || (idx == `HRPC_E_POLL);
  wire is_ser    = (idx >= `HRPC_E_SER0) && (idx < `HRPC_E_DMA);
  wire is_sst    = (idx == `HRPC_E_SER0_ST) || (idx == `HRPC_E_SER1_ST);
  wire is_stx    = (idx == `HRPC_E_SER0_TX) || (idx == `HRPC_E_SER1_TX);
  wire is_dma    = (idx >= `HRPC_E_DMA);
  wire is_dup    = (idx == `HRPC_E_DMA_SU) || (idx == `HRPC_E_DMA_DU);
  wire absent    = newest ? is_dma : is_ser;
  wire cs_gated  = !newest && !chip_select_readback_switch && is_cs4;

  // save skips: poll never read, status only with switch, gated selects
  wire skip_save = absent || (idx == `HRPC_E_POLL) ||
                   (is_sst && !read_serial_status_switch) ||
                   cs_gated;
  // restore skips: read-only, clearing, transmitting, unchanged gated selects
  wire skip_rest = absent || is_poll ||
                   is_sst || is_stx ||
                   (cs_gated && !modified[idx]);

  wire [15:0] entry_addr = `HRPC_PERIPH_BASE + {10'h000, idx, 1'b0};

  // restore data with write-only zero bits and narrow dma upper parts
  wire [15:0] rest_data =
    (newest && is_cs) ? (tab[idx] & ~`HRPC_CS_WR_CLR) :
    is_dup            ? (tab[idx] & `HRPC_DMA_UP_MASK) :
                        tab[idx];

  // interrupt mask applied at halt entry
  wire [15:0] halt_mask =
    (oldest || !irq_during_halt_switch) ? `HRPC_MASK_ALL :
    newest ? (tab[`HRPC_E_MASK] | `HRPC_MASK_IRQ4) :
             tab[`HRPC_E_MASK];
  wire [15:0] mask_addr = `HRPC_PERIPH_BASE + {10'h000, `HRPC_E_MASK, 1'b0};

  // ****************************************************************
  // sequencer
  // ****************************************************************
  wire at_end   = (idx == `HRPC_NENT);
  wire save_st  = (state == ST_SAVE_WAIT) && port_done;
  wire rest_fin = (state == ST_REST) && at_end;

  // next state and bus requests
  always_comb begin
    next_state = state;
    next_idx   = idx;
    port_start = 1'b0;
    port_we    = 1'b0;
    port_addr  = entry_addr;
    port_wdata = rest_data;
    unique case (state)
      ST_IDLE: begin
        next_idx = 5'h00;
        if (halt_req && !halted) next_state = ST_SAVE;
        else if (res_req && halted) next_state = ST_REST;
      end
      ST_SAVE: begin
        if (at_end) begin
          port_start = 1'b1;
          port_we    = 1'b1;
          port_addr  = mask_addr;
          port_wdata = halt_mask;
          next_state = ST_MASK_WAIT;
        end else if (skip_save) begin
          next_idx = idx + 5'h01;
        end else begin
          port_start = 1'b1;
          next_state = ST_SAVE_WAIT;
        end
      end
      ST_SAVE_WAIT: begin
        if (port_done) begin
          next_idx   = idx + 5'h01;
          next_state = ST_SAVE;
        end
      end
      ST_MASK_WAIT: begin
        if (port_done) next_state = ST_IDLE;
      end
      ST_REST: begin
        if (at_end) begin
          next_state = ST_IDLE;
        end else if (skip_rest) begin
          next_idx = idx + 5'h01;
        end else begin
          port_start = 1'b1;
          port_we    = 1'b1;
          next_state = ST_REST_WAIT;
        end
      end
      ST_REST_WAIT: begin
        if (port_done) begin
          next_idx   = idx + 5'h01;
          next_state = ST_REST;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      idx   <= 5'h00;
    end else begin
      state <= next_state;
      idx   <= next_idx;
    end
  end

  // halted flag; resume restores the saved mask in the sweep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) halted <= 1'b0;
    else if (state == ST_MASK_WAIT && port_done) halted <= 1'b1;
    else if (rest_fin) halted <= 1'b0;
  end

  // ****************************************************************
  // snapshot table, one slot per entry
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 20; g++) begin : g_ent
      wire sv_hit = save_st && ((idx == 5'(g)) ||
                    (idx == `HRPC_E_POLLST && 5'(g) == `HRPC_E_POLL));
      wire hw_hit = host_wr && (tix == 5'(g));
      // save capture and host edits
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) tab[g] <= 16'h0000;
        else if (sv_hit) tab[g] <= port_rdata;
        else if (hw_hit) tab[g] <= pwdata[15:0];
      end
      // host write marks, resume completion clears
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) modified[g] <= 1'b0;
        else if (hw_hit) modified[g] <= 1'b1;
        else if (rest_fin) modified[g] <= 1'b0;
      end
    end
  endgenerate

  hrpc_bus_port u_port (
    .clock     (clock),
    .rst_n     (rst_n),
    .start     (port_start),
    .we        (port_we),
    .addr      (port_addr),
    .wdata     (port_wdata),
    .done      (port_done),
    .rdata     (port_rdata),
    .tgt_req   (tgt_req),
    .tgt_we    (tgt_we),
    .tgt_addr  (tgt_addr),
    .tgt_wdata (tgt_wdata),
    .tgt_rdata (tgt_rdata),
    .tgt_rdy   (tgt_rdy)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  localparam logic [15:0] POLL_ADDR =
    `HRPC_PERIPH_BASE + {10'h000, `HRPC_E_POLL, 1'b0};
  wire rd_now = tgt_req && !tgt_we;
  wire wr_now = tgt_req && tgt_we;
  wire [4:0] tgt_ix = tgt_addr[5:1];
  wire ent_rd = psel && !pwrite && hit_tab && !newest;

  // the poll register is never read
  poll_never_a: assert property (@(posedge clock)
    disable iff (!rst_n) rd_now |-> tgt_addr != POLL_ADDR)
    else $error("poll register read");

  // both poll entries agree once halted
  poll_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(halted) |-> tab[`HRPC_E_POLL] == tab[`HRPC_E_POLLST])
    else $error("poll copy mismatch");

  lower_ones_a: assert property (@(posedge clock) disable iff (!rst_n)
    ent_rd && tix == `HRPC_E_LOWER_MEMORY_SELECT_CTRL |-> prdata[5:3] == 3'h7)
    else $error("lower select ones missing");

  mid_ones_a: assert property (@(posedge clock) disable iff (!rst_n)
    ent_rd && tix == `HRPC_E_MBASE |-> prdata[8:3] == 6'h3F)
    else $error("mid base ones missing");

  periph_ones_a: assert property (@(posedge clock)
    disable iff (!rst_n)
    ent_rd && tix == `HRPC_E_PCS |-> prdata[5:3] == 3'h7)
    else $error("peripheral select ones missing");

  upper_ones_a: assert property (@(posedge clock) disable iff (!rst_n)
    ent_rd && tix == `HRPC_E_UPPER_MEMORY_SELECT_CTRL |-> prdata[15:14] == 2'h3 &&
    prdata[5:3] == 3'h7) else $error("upper select ones missing");

  cs_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_now && newest && tgt_ix <= `HRPC_E_UPPER_MEMORY_SELECT_CTRL |-> tgt_wdata[5:4] == 2'h0)
    else $error("select bits 4,5 not zero");

  serial_nowr_a: assert property (@(posedge clock)
    disable iff (!rst_n)
    wr_now |-> !(tgt_ix inside {`HRPC_E_SER0_ST, `HRPC_E_SER0_TX,
                 `HRPC_E_SER1_ST, `HRPC_E_SER1_TX}))
    else $error("serial status or transmit written");

  status_gate_a: assert property (@(posedge clock)
    disable iff (!rst_n) rd_now && !read_serial_status_switch |->
      !(tgt_ix inside {`HRPC_E_SER0_ST, `HRPC_E_SER1_ST}))
    else $error("status read with switch off");

  mask_oldest_a: assert property (@(posedge clock)
    disable iff (!rst_n) state == ST_MASK_WAIT && tgt_req && oldest |->
      tgt_wdata == `HRPC_MASK_ALL) else $error("oldest mask not full");

  irq4_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    state == ST_MASK_WAIT && tgt_req && newest |->
      (tgt_wdata & `HRPC_MASK_IRQ4) != 16'h0000)
    else $error("irq four left enabled");

  halt_done_c: cover property (@(posedge clock) $rose(halted));
  resume_done_c: cover property (@(posedge clock) $fell(halted));
  idp_halt_c: cover property (@(posedge clock)
    $rose(halted) && irq_during_halt_switch && newest);
  rss_read_c: cover property (@(posedge clock)
    rd_now && tgt_ix == `HRPC_E_SER0_ST);
endmodule

// >>> include/hrpc_regs.svh
`ifndef HRPC_REGS_SVH
`define HRPC_REGS_SVH

// ****************************************************************
// apb register map (byte offsets)
// ****************************************************************
`define HRPC_OFS_CTRL    12'h000
`define HRPC_OFS_CMD     12'h004
`define HRPC_OFS_STATUS  12'h008
`define HRPC_OFS_TABLE   12'h040
`define HRPC_OFS_TBL_END 12'h090

// control fields
`define HRPC_CTRL_FAM_LO 0
`define HRPC_CTRL_FAM_HI 1
`define HRPC_CTRL_IDP    2
`define HRPC_CTRL_RSS    3
`define HRPC_CTRL_RCS    4
`define HRPC_CTRL_RESET  5'h00

// command fields
`define HRPC_CMD_HALT    0
`define HRPC_CMD_RESUME  1

// ****************************************************************
// snapshot table entries
// ****************************************************************
`define HRPC_NENT        5'h14
`define HRPC_E_LOWER_MEMORY_SELECT_CTRL      5'h00
`define HRPC_E_MBASE     5'h01
`define HRPC_E_MSIZE     5'h02
`define HRPC_E_PCS       5'h03
`define HRPC_E_UPPER_MEMORY_SELECT_CTRL      5'h04
`define HRPC_E_POLLST    5'h05
`define HRPC_E_POLL      5'h06
`define HRPC_E_MASK      5'h07
`define HRPC_E_SER0      5'h08
`define HRPC_E_SER0_ST   5'h0A
`define HRPC_E_SER0_TX   5'h0B
`define HRPC_E_SER1_ST   5'h0E
`define HRPC_E_SER1_TX   5'h0F
`define HRPC_E_DMA       5'h10
`define HRPC_E_DMA_SU    5'h10
`define HRPC_E_DMA_DU    5'h12

// ****************************************************************
// target side values
// ****************************************************************
`define HRPC_PERIPH_BASE 16'hFF00
`define HRPC_ONES_LOWER_MEMORY_SELECT_CTRL   16'h0038
`define HRPC_ONES_MBASE  16'h01F8
`define HRPC_ONES_PCS    16'h0038
`define HRPC_ONES_UPPER_MEMORY_SELECT_CTRL   16'hC038
`define HRPC_CS_WR_CLR   16'h0030
`define HRPC_DMA_UP_MASK 16'h000F
`define HRPC_MASK_ALL    16'h00FF
`define HRPC_MASK_IRQ4   16'h0010

`endif

// >>> include/hrpc_pkg.sv
package hrpc_pkg;

  typedef enum logic [1:0] {
    HRPC_FAM_OLDEST,
    HRPC_FAM_LATER,
    HRPC_FAM_NEWEST,
    HRPC_FAM_SPARE
  } hrpc_family_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAVE,
    ST_SAVE_WAIT,
    ST_MASK_WAIT,
    ST_REST,
    ST_REST_WAIT
  } hrpc_state_t;

endpackage

// >>> design/hrpc_bus_port.sv
`timescale 1ns/1ns
// ****************************************************************
// single-transfer master towards the peripheral block
// ****************************************************************
module hrpc_bus_port (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  output logic             tgt_req,
  output logic             tgt_we,
  output logic [15:0]      tgt_addr,
  output logic [15:0]      tgt_wdata,
  input  wire logic [15:0] tgt_rdata,
  input  wire logic        tgt_rdy
);
  logic busy;
  wire  finish = busy & tgt_rdy;

  assign tgt_req = busy;

  // request held until the target's ready ends the cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      tgt_we    <= 1'b0;
      tgt_addr  <= 16'h0000;
      tgt_wdata <= 16'h0000;
    end else if (start && !busy) begin
      busy      <= 1'b1;
      tgt_we    <= we;
      tgt_addr  <= addr;
      tgt_wdata <= wdata;
    end else if (finish) begin
      busy      <= 1'b0; // only ready completes the cycle
    end
  end

  // read data and completion pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done  <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      done  <= finish;
      if (finish && !tgt_we) rdata <= tgt_rdata;
    end
  end
endmodule

// >>> tb/hrpc_periph_model.sv
`timescale 1ns/1ns
`include "hrpc_regs.svh"
// ****
// peripheral block model on the target bus
// ****
module hrpc_periph_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        tgt_req,
  input  wire logic        tgt_we,
  input  wire logic [15:0] tgt_addr,
  input  wire logic [15:0] tgt_wdata,
  output logic [15:0]      tgt_rdata,
  output logic             tgt_rdy
);
  logic [15:0] mem [20];
  int          wcnt [20];
  int          rcnt [20];
  logic        poll_acked;
  int          lag;
  logic [4:0]  idx;

  // word index from the byte address above the block base
  assign idx = tgt_addr[5:1];

  // known contents at start
  initial begin
    for (int i = 0; i < 20; i++) begin
      mem[i] = 16'hA520 + 16'(i);
    end
  end

  // answer each cycle after a short or a long lag
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tgt_rdy <= 1'b0;
      tgt_rdata <= 16'h5A5A;
      lag <= 0;
      poll_acked <= 1'b0;
    end else if (tgt_req && tgt_rdy) begin
      tgt_rdy <= 1'b0;           // cycle ends only on ready
      tgt_rdata <= ~tgt_rdata;   // released data does not linger
      lag <= 0;
      if (tgt_we) begin
        mem[idx] <= tgt_wdata;
        wcnt[idx] <= wcnt[idx] + 1;
      end else begin
        rcnt[idx] <= rcnt[idx] + 1;
      end
      if (idx == `HRPC_E_SER0_ST || idx == `HRPC_E_SER1_ST) begin
        mem[idx] <= 16'h0000;    // any access clears status
      end
      if (!tgt_we && idx == `HRPC_E_POLL) begin
        poll_acked <= 1'b1;      // poll read acknowledges
      end
    end else if (tgt_req) begin
      lag <= lag + 1;
      if (lag >= (slow ? 3 : 0)) begin
        tgt_rdy <= 1'b1;
        tgt_rdata <= mem[idx];
      end
    end
  end

  // zero the access counters while the bus is quiet
  task automatic clear_counts();
    for (int i = 0; i < 20; i++) begin
      wcnt[i] = 0;
      rcnt[i] = 0;
    end
  endtask
endmodule

// >>> tb/hrpc_seq_bench.sv
`timescale 1ns/1ns
`include "hrpc_regs.svh"
module hrpc_seq_bench;
  logic        clock, rst_n, psel, penable, pwrite, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, halted, busy, e;
  logic        tgt_req, tgt_we, tgt_rdy;
  logic [15:0] tgt_addr, tgt_wdata, tgt_rdata;
  int          bad_count, checks_done;

  hrpc_seq dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .halted, .busy, .tgt_req,
    .tgt_we, .tgt_addr, .tgt_wdata, .tgt_rdata, .tgt_rdy);
  hrpc_periph_model pm (.clock, .rst_n, .slow, .tgt_req, .tgt_we,
    .tgt_addr, .tgt_wdata, .tgt_rdata, .tgt_rdy);

  // ****
  // helpers
  // ****
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [15:0] pat(input int i);
    return 16'hA520 + 16'(i);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic fail_wait();
    $display("[ERR] %0t wait ran out", $time);
    bad_count++;
    end_sim();
  endtask

  // one apb transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_wait();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // issue a command and wait for the sequencer to go idle
  task automatic run(input logic [31:0] c);
    int n;
    apb(1'b1, `HRPC_OFS_CMD, c);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (busy !== 1'b0 && n < 2000);
    if (busy !== 1'b0) fail_wait();
  endtask

  task automatic tchk(input int i, input logic [15:0] x);
    apb(1'b0, `HRPC_OFS_TABLE + 12'(4 * i), 32'h0);
    chk(q, {16'h0000, x});
  endtask

  // ****
  // scenarios
  // ****
  task automatic s_regs();
    apb(1'b0, `HRPC_OFS_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    chk({31'h0, pready}, 32'h1);
  endtask

  task automatic s_oldest();
    apb(1'b1, `HRPC_OFS_CTRL, 32'h04);
    pm.clear_counts();
    run(32'h1);
    chk({31'h0, halted}, 32'h1);
    apb(1'b0, `HRPC_OFS_STATUS, 32'h0);
    chk(q, 32'h0000_0001);
    chk({16'h0, pm.mem[7]}, 32'h00FF);
    chk({31'h0, pm.poll_acked}, 32'h0);
    tchk(1, 16'h01F8);
    tchk(3, 16'h0038);
    tchk(4, pat(4) | 16'hC038);
    tchk(5, pat(5));
    tchk(6, pat(5));
    tchk(17, pat(17));
    apb(1'b1, `HRPC_OFS_TABLE, 32'h1234);
    tchk(0, 16'h123C);
    run(32'h2);
    chk(32'(pm.wcnt[0]), 32'h1);
    chk(32'(pm.wcnt[1]), 32'h0);
    chk({16'h0, pm.mem[0]}, 32'h1234);
    chk(32'(pm.wcnt[5] + pm.wcnt[6]), 32'h0);
    chk({16'h0, pm.mem[7]}, {16'h0, pat(7)});
    run(32'h1);
    run(32'h2);
    chk(32'(pm.wcnt[0]), 32'h1);
  endtask

  task automatic s_later();
    apb(1'b1, `HRPC_OFS_CTRL, 32'h01);
    run(32'h1);
    chk({16'h0, pm.mem[7]}, 32'h00FF);
    run(32'h2);
    apb(1'b1, `HRPC_OFS_CTRL, 32'h05);
    run(32'h1);
    chk({16'h0, pm.mem[7]}, {16'h0, pat(7)});
    run(32'h2);
    chk({31'h0, halted}, 32'h0);
    // spare family code with chip-select readback on
    apb(1'b1, `HRPC_OFS_CTRL, 32'h13);
    run(32'h1);
    chk({16'h0, pm.mem[7]}, 32'h00FF);
    tchk(2, pat(2));
    pm.clear_counts();
    run(32'h2);
    chk(32'(pm.wcnt[2]), 32'h1);
  endtask

  task automatic s_newest();
    slow <= 1'b1;
    apb(1'b1, `HRPC_OFS_CTRL, 32'h0E);
    pm.clear_counts();
    run(32'h1);
    chk({16'h0, pm.mem[7]}, {16'h0, pat(7) | 16'h0010});
    chk(32'(pm.rcnt[10] + pm.rcnt[14]), 32'h2);
    chk({16'h0, pm.mem[10]}, 32'h0);
    chk({31'h0, pm.poll_acked}, 32'h0);
    tchk(9, pat(9));
    tchk(10, pat(10));
    run(32'h2);
    for (int i = 0; i < 5; i++) begin
      chk(32'(pm.wcnt[i]), 32'h1);
    end
    chk({16'h0, pm.mem[1]}, {16'h0, pat(1) & 16'hFFCF});
    chk(32'(pm.wcnt[10] + pm.wcnt[11]), 32'h0);
    chk(32'(pm.wcnt[14] + pm.wcnt[15]), 32'h0);
    chk({16'h0, pm.mem[7]}, {16'h0, pat(7)});
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slow = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    s_regs();
    s_oldest();
    s_later();
    s_newest();
    end_sim();
  end
endmodule
